//--- reset_pin_model.sv
// Behavioural model of the external reset pin and the party that drives it.
// Assumes one-cycle start requests, synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module reset_pin_model (
   // Clock
   input wire logic core_clk,
   // Request from the bench
   input wire logic start,
   input wire logic [15:0] low_cycles,
   // Pin side
   output logic reset_pin_n,
   output logic busy
);
   // ==========================================================================
   // Pin driver
   // The pin has a pull-up, so it rests high whenever no pulse is driven.
   logic [15:0] left;
   initial begin
      reset_pin_n = 1'b1;
      busy = 1'b0;
      left = 16'h0000;
   end
   always @(posedge core_clk) begin
      if (start && !busy) begin
         left <= low_cycles;
         busy <= 1'b1;
         reset_pin_n <= 1'b0;
      end else if (busy) begin
         left <= left - 16'h0001;
         if (left <= 16'h0001) begin
            busy <= 1'b0;
            reset_pin_n <= 1'b1;
         end
      end
   end
endmodule : reset_pin_model
`default_nettype wire

//--- sleep_reset_pkg.sv
// Types shared by the sleep and reset block.
// Assumes nothing beyond a SystemVerilog compiler.
package sleep_reset_pkg;
   // ==========================================================================
   // Sleep modes and controller states
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_POWER_DOWN,
      MODE_STANDBY
   } sleep_mode_t;
   typedef enum logic [1:0] {
      ST_RESET,
      ST_RUN,
      ST_SLEEP,
      ST_WAKE
   } ctrl_state_t;
endpackage : sleep_reset_pkg

//--- sleep_reset_regs.svh
// Register offsets, field positions, reset values and timing counts of the sleep and reset block.
// Assumes 32-bit APB with word-aligned registers; included by bare name.
`ifndef SLEEP_RESET_REGS_SVH
`define SLEEP_RESET_REGS_SVH
// ==========================================================================
// Register byte offsets
`define OFS_SLEEP_CTRL 12'h000
`define OFS_RESET_CAUSE 12'h004
`define OFS_INPUT_DIS 12'h008
`define OFS_ANALOG_CTRL 12'h00C
`define OFS_STATUS 12'h010
// ==========================================================================
// Field positions of the sleep control register
`define SC_MODE_LO 0
`define SC_MODE_HI 1
`define SC_ENABLE 2
// ==========================================================================
// Field positions of the reset cause register
`define RC_PWR 0
`define RC_PIN 1
`define RC_BROWN 2
`define RC_WDOG 3
// ==========================================================================
// Field positions of the analog control register
`define AC_CMP_OFF 0
`define AC_CMP_REF 1
// ==========================================================================
// Reset values and timing
`define SC_RESET 3'h0
`define RC_RESET 4'h0
`define INPUT_DIS_RESET 8'h00
`define AC_RESET 2'h0
`define STANDBY_WAKE_CYC 6
`define PIN_PULSE_NS 2500
`define CLK_PERIOD_NS 5
`define TIMEOUT_DEFAULT 32'd4200
`define BOD_OFF_CODE 3'b111
`endif

//--- sleep_wake_and_reset_control.sv
// Sleep, wake and reset sequencing for a small microcontroller, with an APB register slave.
// Assumes all inputs synchronous to core_clk; analog detectors deliver plain levels.
//
// How it works
// - Mode field 10 plus crystal clock option enters Standby on sleep request.
// - Standby equals Power-down but keeps the main oscillator running.
// - A wake event in Standby resumes the core after six clocks.
// - Per-mode clock gating and wake source qualification per the mode table.
// - In Power-down and Standby, IRQ zero wakes only when level sensed.
// - Comparator is forced off in every sleep mode except Idle.
// - Comparator using the reference keeps the reference on in any mode.
// - An enabled brown-out detector stays on in every sleep mode.
// - Reference is powered only when brown-out detector or comparator needs it.
// - An enabled watchdog keeps running in every sleep mode.
// - Input buffers off while I/O clock stops, except wake-detect pins.
// - Writing the input-disable register switches off those pin buffers.
// - Reset returns the sleep, input-disable and analog registers to initial values; core restarts at the vector.
// - Port reset output is registered and follows any reset source one clock later.
// - Delay counter stretches internal reset by the TIMEOUT_CYC parameter time-out.
// - Four reset sources: power-on, pin, watchdog and brown-out.
// - Pin low beyond the minimum pulse length causes an external reset.
// - Watchdog resets only when expired, enabled and not in interrupt mode.
// - Brown-out reset while supply is low and the detector is enabled.
// - Power-on rise starts the delay; supply fall reasserts reset at once.
// - Mode field decode: 00 Idle, 01 and 11 Power-down, 10 Standby.
// - Sleep is entered only when the sleep enable bit is one.
// - Watchdog reset is a one-clock pulse; delay starts as it falls.
// - Per-source flags; power-on clears the others, only zero write clears it.
`include "sleep_reset_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_and_reset_control #(
   parameter int unsigned PINS = 8,
   parameter logic [31:0] TIMEOUT_CYC = `TIMEOUT_DEFAULT
) (
   // Clock, reset and enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core and fuses
   input wire logic sleep_req,
   input wire logic crystal_clock_sel,
   input wire logic [2:0] brownout_level_fuses,
   // Reset sources
   input wire logic supply_above_por,
   input wire logic reset_pin_n,
   input wire logic watchdog_expired,
   input wire logic watchdog_enable,
   input wire logic watchdog_irq_mode,
   input wire logic supply_below_bot,
   // Wake sources
   input wire logic external_irq_zero,
   input wire logic external_irq_zero_level,
   input wire logic external_irq_one,
   input wire logic pin_change_irq,
   input wire logic serial_start_irq,
   input wire logic other_irq,
   input wire logic [PINS-1:0] wake_pin_mask,
   // Outputs
   output logic internal_reset,
   output logic port_reset,
   output logic core_clock_domain,
   output logic program_memory_clock_domain,
   output logic peripheral_io_clock_domain,
   output logic oscillator_on,
   output logic comparator_enable,
   output logic reference_enable,
   output logic brownout_detector_on,
   output logic watchdog_run,
   output logic [PINS-1:0] input_buffer_en,
   output logic sleeping
);
   localparam int unsigned PIN_CYC = (`PIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   // ==========================================================================
   // State record
   typedef struct packed {
      sleep_reset_pkg::ctrl_state_t st;
      sleep_reset_pkg::sleep_mode_t mode;
      logic [2:0] sleep_ctrl;
      logic [3:0] cause;
      logic [PINS-1:0] input_dis;
      logic [1:0] analog;
      logic [31:0] tout;
      logic [15:0] pin_cnt;
      logic [2:0] wake_cnt;
      logic wd_pulse;
      logic wd_prev;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic internal_reset;
      logic core_clk_on;
      logic flash_clk_on;
      logic io_clk_on;
      logic osc_on;
      logic cmp_en;
      logic ref_en;
      logic bod_on;
      logic wd_run;
      logic [PINS-1:0] ibuf;
      logic slp;
      logic prst;
   } state_t;

   state_t cur;
   state_t next_cur;

   // ==========================================================================
   // Helpers
   function automatic sleep_reset_pkg::sleep_mode_t decode_mode(input logic [1:0] f);
      case (f)
         2'b00: decode_mode = sleep_reset_pkg::MODE_IDLE;
         2'b10: decode_mode = sleep_reset_pkg::MODE_STANDBY;
         default: decode_mode = sleep_reset_pkg::MODE_POWER_DOWN;
      endcase
   endfunction : decode_mode

   logic bod_en;
   logic pin_rst;
   logic wd_rst;
   logic bod_rst;
   logic por_rst;
   logic any_src;
   logic wake_any;
   logic wake_deep;
   logic apb_go;
   logic [3:0] cause_set;

   assign bod_en = brownout_level_fuses != `BOD_OFF_CODE;
   assign pin_rst = cur.pin_cnt >= 16'(PIN_CYC);
   assign wd_rst = watchdog_expired && watchdog_enable && !watchdog_irq_mode;
   assign bod_rst = bod_en && supply_below_bot;
   assign por_rst = !supply_above_por;
   assign any_src = por_rst || pin_rst || cur.wd_pulse || bod_rst;
   // Level-only IRQ zero wake in deep modes; edge triggering needs the stopped I/O clock.
   assign wake_deep = (external_irq_zero && external_irq_zero_level) || external_irq_one
      || pin_change_irq || serial_start_irq;
   assign wake_any = wake_deep || external_irq_zero || other_irq;
   assign apb_go = psel && penable && !cur.pready;
   // Flags raised this cycle, in the bit order of the reset cause register.
   assign cause_set = {cur.wd_pulse, bod_rst, pin_rst, por_rst};

   // ==========================================================================
   // Next-state logic
   always_comb begin
      next_cur = cur;
      next_cur.pready = 1'b0;
      next_cur.pslverr = 1'b0;
      next_cur.wd_prev = wd_rst;
      next_cur.wd_pulse = wd_rst && !cur.wd_prev;
      next_cur.pin_cnt = reset_pin_n ? 16'h0000 : (pin_rst ? cur.pin_cnt : cur.pin_cnt + 16'h0001);
      if (por_rst) begin
         next_cur.cause = {3'h0, 1'b1};
      end else begin
         if (pin_rst) next_cur.cause[`RC_PIN] = 1'b1;
         if (cur.wd_pulse) next_cur.cause[`RC_WDOG] = 1'b1;
         if (bod_rst) next_cur.cause[`RC_BROWN] = 1'b1;
      end
      if (apb_go) begin
         next_cur.pready = 1'b1;
         if (pwrite) begin
            case (paddr)
               `OFS_SLEEP_CTRL: next_cur.sleep_ctrl = pwdata[2:0];
               // Zero writes clear; a source firing the same cycle keeps its flag.
               `OFS_RESET_CAUSE: next_cur.cause = por_rst ? next_cur.cause
                  : ((cur.cause & pwdata[3:0]) | cause_set);
               `OFS_INPUT_DIS: next_cur.input_dis = pwdata[PINS-1:0];
               `OFS_ANALOG_CTRL: next_cur.analog = pwdata[1:0];
               `OFS_STATUS: next_cur.pslverr = 1'b0;
               default: next_cur.pslverr = 1'b1;
            endcase
         end else begin
            case (paddr)
               `OFS_SLEEP_CTRL: next_cur.prdata = {29'h0, cur.sleep_ctrl};
               `OFS_RESET_CAUSE: next_cur.prdata = {28'h0, cur.cause};
               `OFS_INPUT_DIS: next_cur.prdata = 32'(cur.input_dis);
               `OFS_ANALOG_CTRL: next_cur.prdata = {30'h0, cur.analog};
               `OFS_STATUS: next_cur.prdata = {27'h0, cur.mode, cur.st, cur.internal_reset};
               default: begin
                  next_cur.prdata = 32'h0000_0000;
                  next_cur.pslverr = 1'b1;
               end
            endcase
         end
      end
      case (cur.st)
         sleep_reset_pkg::ST_RESET: begin
            next_cur.internal_reset = 1'b1;
            if (any_src) next_cur.tout = 32'h0000_0000;
            else if (cur.tout >= TIMEOUT_CYC - 32'h0000_0001) begin
               next_cur.internal_reset = 1'b0;
               next_cur.st = sleep_reset_pkg::ST_RUN;
            end else next_cur.tout = cur.tout + 32'h0000_0001;
         end
         sleep_reset_pkg::ST_RUN: begin
            // Standby needs a crystal; otherwise the 10 code falls back to Power-down.
            if (sleep_req && cur.sleep_ctrl[`SC_ENABLE]) begin
               next_cur.mode = decode_mode(cur.sleep_ctrl[`SC_MODE_HI:`SC_MODE_LO]);
               if (next_cur.mode == sleep_reset_pkg::MODE_STANDBY && !crystal_clock_sel)
                  next_cur.mode = sleep_reset_pkg::MODE_POWER_DOWN;
               next_cur.st = sleep_reset_pkg::ST_SLEEP;
            end
         end
         sleep_reset_pkg::ST_SLEEP: begin
            if ((cur.mode == sleep_reset_pkg::MODE_IDLE) ? wake_any : wake_deep) begin
               next_cur.st = sleep_reset_pkg::ST_WAKE;
               next_cur.wake_cnt = 3'h1;
            end
         end
         sleep_reset_pkg::ST_WAKE: begin
            // Idle and Power-down resume through the same six-cycle path in this model.
            if (cur.wake_cnt >= 3'(`STANDBY_WAKE_CYC)) next_cur.st = sleep_reset_pkg::ST_RUN;
            else next_cur.wake_cnt = cur.wake_cnt + 3'h1;
         end
         default: next_cur.st = sleep_reset_pkg::ST_RESET;
      endcase
      if (any_src) begin
         next_cur.st = sleep_reset_pkg::ST_RESET;
         next_cur.internal_reset = 1'b1;
         next_cur.tout = 32'h0000_0000;
         next_cur.sleep_ctrl = `SC_RESET;
         next_cur.input_dis = `INPUT_DIS_RESET;
         next_cur.analog = `AC_RESET;
      end
      // Clock and power controls, from the state about to be entered.
      // The core clock stays off through the wake count, so resume lands on the cycle after its last count.
      next_cur.core_clk_on = next_cur.st != sleep_reset_pkg::ST_SLEEP
         && next_cur.st != sleep_reset_pkg::ST_WAKE;
      next_cur.flash_clk_on = next_cur.core_clk_on;
      next_cur.io_clk_on = next_cur.core_clk_on || next_cur.mode == sleep_reset_pkg::MODE_IDLE;
      next_cur.osc_on = next_cur.io_clk_on || next_cur.mode == sleep_reset_pkg::MODE_STANDBY;
      next_cur.cmp_en = !next_cur.analog[`AC_CMP_OFF] && next_cur.io_clk_on;
      next_cur.ref_en = bod_en || (!next_cur.analog[`AC_CMP_OFF] && next_cur.analog[`AC_CMP_REF]);
      next_cur.bod_on = bod_en;
      next_cur.wd_run = watchdog_enable;
      next_cur.ibuf = ~next_cur.input_dis & (next_cur.io_clk_on ? {PINS{1'b1}} : wake_pin_mask);
      next_cur.slp = next_cur.st == sleep_reset_pkg::ST_SLEEP;
      next_cur.prst = any_src || next_cur.internal_reset;
   end

   // ==========================================================================
   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
         cur.st <= sleep_reset_pkg::ST_RESET;
         cur.internal_reset <= 1'b1;
         cur.cause <= `RC_RESET;
         cur.prst <= 1'b1;
      end else if (clk_en) begin
         cur <= next_cur;
      end
   end

   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign internal_reset = cur.internal_reset;
   // Port reset is registered, so it trails a source by one clock; limitation of flop outputs.
   assign port_reset = cur.prst;
   assign core_clock_domain = cur.core_clk_on;
   assign program_memory_clock_domain = cur.flash_clk_on;
   assign peripheral_io_clock_domain = cur.io_clk_on;
   assign oscillator_on = cur.osc_on;
   assign comparator_enable = cur.cmp_en;
   assign reference_enable = cur.ref_en;
   assign brownout_detector_on = cur.bod_on;
   assign watchdog_run = cur.wd_run;
   assign input_buffer_en = cur.ibuf;
   assign sleeping = cur.slp;

   // ==========================================================================
   // Checks
   sequence s_wake_start;
      cur.st == sleep_reset_pkg::ST_SLEEP && next_cur.st == sleep_reset_pkg::ST_WAKE;
   endsequence
   a_standby_wake_time: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en || any_src)
      s_wake_start |=> !core_clock_domain [*6] ##1 core_clock_domain)
      else $error("wake did not take six cycles");
   a_sleep_needs_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !any_src && cur.st == sleep_reset_pkg::ST_RUN && !cur.sleep_ctrl[`SC_ENABLE]
      |=> cur.st != sleep_reset_pkg::ST_SLEEP)
      else $error("sleep entered without enable");
   a_cmp_off_deep: assert property (@(posedge core_clk) disable iff (!rst_n)
      sleeping && cur.mode != sleep_reset_pkg::MODE_IDLE |-> !comparator_enable)
      else $error("comparator on in deep sleep");
   a_standby_osc_on: assert property (@(posedge core_clk) disable iff (!rst_n)
      sleeping |-> oscillator_on == (cur.mode != sleep_reset_pkg::MODE_POWER_DOWN))
      else $error("oscillator wrong in sleep");
   a_src_asserts_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && any_src |=> internal_reset && cur.tout == 32'h0000_0000)
      else $error("source did not hold reset");
   a_wd_single_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
      cur.wd_pulse && clk_en |=> !cur.wd_pulse)
      else $error("watchdog pulse too long");
   a_pin_cause_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && pin_rst && !por_rst |=> cur.cause[`RC_PIN])
      else $error("pin flag not set");
   a_wdog_flag_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cur.wd_pulse && !por_rst |=> cur.cause[`RC_WDOG])
      else $error("watchdog flag lost");
   a_ref_power: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(reference_enable) |-> $past(bod_en) || cur.analog[`AC_CMP_REF])
      else $error("reference on without user");
endmodule : sleep_wake_and_reset_control
`default_nettype wire

//--- sleep_wake_and_reset_control_tb_top.sv
// Self-checking bench for the sleep, wake and reset block.
// Assumes the reset pin model and the register offsets of the shared header.
`include "sleep_reset_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_and_reset_control_tb_top;
   // ==========================================================================
   // Signals
   // The time-out is shortened so every release is measured in a few cycles.
   localparam int TO = 20;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, sleep_req, xtal;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic por_ok, wd_exp, wd_en, wd_irq, below_bot, irq0, irq0_lvl, irq1, pcint, ser, oth;
   logic [2:0] brownout_detector;
   logic [7:0] ibuf;
   logic ires, pres, c_core, c_mem, c_io, osc, cmp, vref, bod_on, wd_run, slp;
   logic pin_go, pin_n, pin_busy, ce;
   logic [15:0] pin_len;
   int error_cnt, n_checks, n;
   sleep_wake_and_reset_control #(.PINS(8), .TIMEOUT_CYC(TO)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .clk_en(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .crystal_clock_sel(xtal),
      .brownout_level_fuses(brownout_detector), .supply_above_por(por_ok), .reset_pin_n(pin_n),
      .watchdog_expired(wd_exp), .watchdog_enable(wd_en), .watchdog_irq_mode(wd_irq),
      .supply_below_bot(below_bot), .external_irq_zero(irq0),
      .external_irq_zero_level(irq0_lvl), .external_irq_one(irq1), .pin_change_irq(pcint),
      .serial_start_irq(ser), .other_irq(oth), .wake_pin_mask(8'h0C),
      .internal_reset(ires), .port_reset(pres), .core_clock_domain(c_core),
      .program_memory_clock_domain(c_mem), .peripheral_io_clock_domain(c_io),
      .oscillator_on(osc), .comparator_enable(cmp), .reference_enable(vref),
      .brownout_detector_on(bod_on), .watchdog_run(wd_run), .input_buffer_en(ibuf),
      .sleeping(slp));
   reset_pin_model pin_u (.core_clk(core_clk), .start(pin_go), .low_cycles(pin_len),
      .reset_pin_n(pin_n), .busy(pin_busy));
   // ==========================================================================
   // Shared tasks
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task hang;
      error_cnt++;
      $display("[ERR] wait bound expected done seen stuck");
      final_report();
   endtask : hang
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
         if (k > 20) hang();
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rd, e);
   endtask : rdc
   // Counts edges after the sampling edge until a flag settles.
   task count_until(input bit want_core, input int lim);
      n = 0;
      @(posedge core_clk);
      do begin
         @(posedge core_clk);
         #1;
         n++;
         if (n > lim) hang();
      end while (want_core ? (c_core !== 1'b1) : (ires !== 1'b0));
      @(posedge core_clk);
   endtask : count_until
   task rel_time(input string nm);
      count_until(1'b0, 100);
      chk(nm, {31'h0, n >= TO - 2 && n <= TO + 2}, 32'h0000_0001);
   endtask : rel_time
   task go_sleep(input logic [2:0] c);
      apb(1'b1, `OFS_SLEEP_CTRL, {29'h0, c});
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask : go_sleep
   task pin_wake;
      @(posedge core_clk);
      pcint <= 1'b1;
      count_until(1'b1, 40);
      chk("pin change wake", n, 6);
      pcint <= 1'b0;
   endtask : pin_wake
   task src(input int k, input logic v);
      case (k)
         0: oth <= v;
         1: irq1 <= v;
         2: ser <= v;
         default: irq0 <= v;
      endcase
   endtask : src
   // ==========================================================================
   // Scenarios
   task t_start;
      rel_time("power-up release");
      rdc("sleep ctrl", `OFS_SLEEP_CTRL, 32'h0000_0000);
      rdc("input disable", `OFS_INPUT_DIS, 32'h0000_0000);
      rdc("analog ctrl", `OFS_ANALOG_CTRL, 32'h0000_0000);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk("unmapped error", {31'h0, err}, 32'h0000_0001);
      ce <= 1'b0;
      por_ok <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      chk("frozen by enable", {31'h0, ires}, 32'h0000_0000);
      @(posedge core_clk);
      ce <= 1'b1;
      por_ok <= 1'b1;
      go_sleep(3'b010);
      chk("sleep without enable", {31'h0, slp}, 32'h0000_0000);
      $display("test start done");
   endtask : t_start
   task t_modes;
      logic [3:0] e;
      for (int m = 0; m < 4; m++) begin
         go_sleep({1'b1, m[1:0]});
         e = (m == 0) ? 4'b0011 : (m == 2) ? 4'b0001 : 4'b0000;
         chk("clock domains", {28'h0, c_core, c_mem, c_io, osc}, {28'h0, e});
         chk("comparator", {31'h0, cmp}, {31'h0, m == 0});
         chk("input buffers", {24'h0, ibuf}, m == 0 ? 32'h0000_00FF : 32'h0000_000C);
         @(posedge core_clk);
         if (m == 1) begin
            oth <= 1'b1;
            irq0 <= 1'b1;
            repeat (20) @(posedge core_clk);
            #1;
            chk("deep sleep held", {31'h0, slp}, 32'h0000_0001);
            @(posedge core_clk);
            oth <= 1'b0;
            irq0 <= 1'b0;
            @(posedge core_clk);
         end
         if (m == 3) irq0_lvl <= 1'b1;
         src(m, 1'b1);
         count_until(1'b1, 40);
         chk("wake delay", n, 6);
         src(m, 1'b0);
      end
      xtal <= 1'b0;
      go_sleep(3'b110);
      chk("standby needs crystal", {31'h0, osc}, 32'h0000_0000);
      pin_wake();
      xtal <= 1'b1;
      $display("test modes done");
   endtask : t_modes
   task t_analog;
      brownout_detector <= 3'b111;
      wd_en <= 1'b1;
      apb(1'b1, `OFS_ANALOG_CTRL, 32'h0000_0002);
      go_sleep(3'b101);
      chk("reference kept", {31'h0, vref}, 32'h0000_0001);
      chk("watchdog runs", {31'h0, wd_run}, 32'h0000_0001);
      chk("detector off", {31'h0, bod_on}, 32'h0000_0000);
      pin_wake();
      apb(1'b1, `OFS_ANALOG_CTRL, 32'h0000_0003);
      @(posedge core_clk);
      #1;
      chk("reference off", {31'h0, vref}, 32'h0000_0000);
      brownout_detector <= 3'b110;
      go_sleep(3'b101);
      chk("detector on", {30'h0, bod_on, vref}, 32'h0000_0003);
      pin_wake();
      $display("test analog done");
   endtask : t_analog
   task t_pin(input logic [15:0] len);
      int k;
      pin_len <= len;
      pin_go <= 1'b1;
      @(posedge core_clk);
      pin_go <= 1'b0;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
         if (k > 1000) hang();
      end while (pin_busy !== 1'b0);
   endtask : t_pin
   task t_sources;
      apb(1'b1, `OFS_INPUT_DIS, 32'h0000_00A5);
      #1;
      chk("disabled buffers", {24'h0, ibuf}, 32'h0000_005A);
      t_pin(16'd400);
      repeat (3) @(posedge core_clk);
      chk("short pin pulse", {31'h0, ires}, 32'h0000_0000);
      t_pin(16'd520);
      chk("long pin pulse", {30'h0, ires, pres}, 32'h0000_0003);
      rel_time("pin release");
      rdc("buffers cleared", `OFS_INPUT_DIS, 32'h0000_0000);
      wd_exp <= 1'b1;
      @(posedge core_clk);
      wd_exp <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("watchdog irq mode", {31'h0, ires}, 32'h0000_0000);
      wd_irq <= 1'b0;
      wd_exp <= 1'b1;
      @(posedge core_clk);
      wd_exp <= 1'b0;
      rel_time("watchdog release");
      brownout_detector <= 3'b111;
      below_bot <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("detector off no reset", {31'h0, ires}, 32'h0000_0000);
      brownout_detector <= 3'b110;
      repeat (3) @(posedge core_clk);
      below_bot <= 1'b0;
      repeat (10) @(posedge core_clk);
      below_bot <= 1'b1;
      @(posedge core_clk);
      below_bot <= 1'b0;
      rel_time("restart on reassert");
      rdc("cause flags", `OFS_RESET_CAUSE, 32'h0000_000E);
      apb(1'b1, `OFS_RESET_CAUSE, 32'h0000_000A);
      rdc("cause clear", `OFS_RESET_CAUSE, 32'h0000_000A);
      por_ok <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("power-on reset", {30'h0, ires, pres}, 32'h0000_0003);
      @(posedge core_clk);
      por_ok <= 1'b1;
      rel_time("power-on release");
      rdc("power-on cause", `OFS_RESET_CAUSE, 32'h0000_0001);
      apb(1'b1, `OFS_RESET_CAUSE, 32'h0000_0000);
      rdc("power-on clear", `OFS_RESET_CAUSE, 32'h0000_0000);
      $display("test sources done");
   endtask : t_sources
   // ==========================================================================
   // Clock and main sequence
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      {rst_n, psel, penable, pwrite, sleep_req, wd_exp, wd_en, below_bot} = 8'h00;
      {irq0, irq0_lvl, irq1, pcint, ser, oth, pin_go} = 7'h00;
      {xtal, por_ok, wd_irq} = 3'b111;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      brownout_detector = 3'b111;
      pin_len = 16'h0000;
      ce = 1'b1;
      error_cnt = 0;
      n_checks = 0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      t_start();
      t_modes();
      t_analog();
      t_sources();
      final_report();
   end
endmodule : sleep_wake_and_reset_control_tb_top
`default_nettype wire
